// ===== hw/oifr_chan_regs.sv
// Register bank of one OFDM TRANSFORM_SATURATE channel with coefficient store and sticky status.
// Assumes datapath events arrive on core_clk_i and software uses Avalon-MM.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module oifr_chan_regs
   import oifr_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [13:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic transform_saturate_out_valid_i,
   input wire logic proc_stop_evt_i,
   input wire logic in_overflow_evt_i,
   input wire logic in_underflow_evt_i,
   input wire logic [13:0] sat_evt_i,
   input wire logic [6:0] coef_rd_idx_i,
   output logic [29:0] coef_rd_data_o,
   output logic prbs_enable_o,
   output logic [12:0] prbs_upper_edge_o,
   output logic [12:0] prbs_lower_edge_o,
   output logic [15:0] loop_count_o,
   output logic loop_count_en_o,
   output logic loop_wrap_o,
   output logic tone_output_sel_o,
   output logic numeric_prog_sel_o,
   output logic rolloff_reverse_o,
   output logic [8:0] rolloff_period_o,
   output logic [10:0] cyclic_prefix_len_o,
   output logic subcarrier_count_sel_o,
   output logic [29:0] osc_freq_word_o,
   output logic freq_word_load_o,
   output logic [7:0] first_gain_stage_o,
   output logic [7:0] second_gain_stage_o,
   output logic [3:0] buf_one_ptr_offset_o,
   output logic [3:0] buf_two_ptr_offset_o,
   output logic [11:0] stage7_inphase_power_threshold_o,
   output logic [11:0] stage7_quadrature_power_threshold_o,
   output logic [11:0] stage8_inphase_power_threshold_o,
   output logic [11:0] stage8_quadrature_power_threshold_o,
   output logic chan_irq_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ack; // Bus answer cycle
      logic [31:0] rdata; // Captured read data
      logic prbs_en; // Test pattern mode
      logic [25:0] band; // Upper and lower edges
      logic [16:0] loop; // Loop value and enable
      logic [15:0] loop_cnt; // Running loop counter
      logic loop_wrap; // Counter wrap pulse
      logic tone; // Tone output select
      logic numsel; // Numeric programming
      logic rev; // Reverse coefficient fetch
      logic [8:0] rp; // Raw rolloff field
      logic [10:0] cp; // Raw prefix field
      logic subc; // Subcarrier count select
      logic [8:0] rp_dec; // Decoded rolloff period
      logic [10:0] cp_dec; // Decoded prefix length
      logic [29:0] fcw; // Oscillator frequency word
      logic load; // Load pulse
      logic [7:0] g8; // Second gain stage
      logic [7:0] g7; // First gain stage
      logic [6:0] caddr; // Coefficient write address
      logic [29:0] crd; // Coefficient fetch data
      logic [3:0] off1; // Buffer one offset
      logic [3:0] off2; // Buffer two offset
      logic stop; // Sticky stop flag
      logic ovf; // Sticky overflow flag
      logic unf; // Sticky underflow flag
      logic [2:0] ie; // Stop/overflow/underflow enables
      logic [13:0] saturation_status; // Sticky saturation flags
      logic [23:0] pwr7; // First stage thresholds
      logic [23:0] pwr8; // Second stage thresholds
      logic [127:0][29:0] mem; // Rolloff coefficient array
   } oifr_state_t;

   oifr_state_t st_r; // Registered state
   oifr_state_t st_nxt; // Next state
   logic [11:0] widx; // Word index of request
   logic acc_wr; // Write takes effect now
   logic [31:0] rd_view; // Read view of addressed register
   logic [31:0] be_mask; // Byte lane mask
   logic [31:0] wd; // Lane-merged write data

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // Enumerated or numeric rolloff period
   function automatic logic [8:0] dec_rolloff(input logic numeric, input logic [8:0] f);
      logic [8:0] r;
      r = 9'h000;
      if (numeric) begin
         r = (f > ROLLOFF_MAX) ? ROLLOFF_MAX : f;
      end else if (f[2:0] <= 3'h4) begin
         r = 9'(f[2:0] * ROLLOFF_STEP);
      end
      return r;
   endfunction

   // Enumerated or numeric cyclic prefix
   function automatic logic [10:0] dec_prefix(input logic numeric, input logic [10:0] f);
      logic [10:0] r;
      r = PREFIX_E0;
      if (numeric) begin
         r = (f > PREFIX_MAX) ? PREFIX_MAX : f;
      end else begin
         unique case (f[2:0])
            3'h1: r = PREFIX_E1;
            3'h2: r = PREFIX_E2;
            3'h3: r = PREFIX_E3;
            3'h4: r = PREFIX_MAX;
            default: r = PREFIX_E0;
         endcase
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Bus decode and read view
   // ---------------------------------------------------------------
   always_comb begin
      widx = avs_address_i[13:2];
      acc_wr = avs_write_i & st_r.ack;
      be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                 {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      // Unmapped words read as zero
      rd_view = RST_ZERO;
      unique case (widx)
         IDX_PRBS_MODE: rd_view = {31'h0, st_r.prbs_en};
         IDX_PRBS_BAND: rd_view = {6'h0, st_r.band};
         IDX_PRBS_LOOP: rd_view = {15'h0, st_r.loop};
         IDX_TRANSFORM_SATURATE_CONFIG: rd_view = {4'h0, st_r.tone, st_r.numsel, st_r.rev, st_r.rp,
                                  4'h0, st_r.cp, st_r.subc};
         IDX_FREQ_WORD: rd_view = {2'h0, st_r.fcw};
         // Load bit reads back as zero
         IDX_GAIN_LOAD: rd_view = {16'h0, st_r.g8, st_r.g7};
         IDX_COEF_ADDR: rd_view = {25'h0, st_r.caddr};
         IDX_COEF_DATA: rd_view = {2'h0, st_r.mem[st_r.caddr]};
         IDX_FIFO_CS: rd_view = {st_r.off1, st_r.off2, 17'h0, transform_saturate_out_valid_i,
                                 st_r.stop, st_r.ovf, st_r.unf, st_r.ie};
         IDX_SAT_STAT: rd_view = {18'h0, st_r.saturation_status};
         IDX_STG7_PWR: rd_view = {4'h0, st_r.pwr7[23:12], 4'h0, st_r.pwr7[11:0]};
         IDX_STG8_PWR: rd_view = {4'h0, st_r.pwr8[23:12], 4'h0, st_r.pwr8[11:0]};
         default: rd_view = RST_ZERO;
      endcase
      wd = (rd_view & ~be_mask) | (avs_writedata_i & be_mask);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // One wait state per access
      st_nxt.ack = (avs_read_i | avs_write_i) & ~st_r.ack;
      if (avs_read_i && !st_r.ack) begin
         st_nxt.rdata = rd_view;
      end
      st_nxt.load = 1'b0;
      st_nxt.loop_wrap = 1'b0;

      st_nxt.rp_dec = dec_rolloff(st_r.numsel, st_r.rp);
      st_nxt.cp_dec = dec_prefix(st_r.numsel, st_r.cp);

      st_nxt.crd = st_r.rev ? st_r.mem[~coef_rd_idx_i] : st_r.mem[coef_rd_idx_i];

      if (st_r.prbs_en && st_r.loop[POS_LOOP_EN]) begin
         if (st_r.loop_cnt == st_r.loop[15:0]) begin
            st_nxt.loop_cnt = 16'h0000;
            st_nxt.loop_wrap = 1'b1;
         end else begin
            st_nxt.loop_cnt = st_r.loop_cnt + 16'h0001;
         end
      end else begin
         st_nxt.loop_cnt = 16'h0000;
      end

      // Register writes at the accepting edge
      if (acc_wr) begin
         unique case (widx)
            IDX_PRBS_MODE: st_nxt.prbs_en = wd[0];
            IDX_PRBS_BAND: st_nxt.band = wd[25:0];
            IDX_PRBS_LOOP: st_nxt.loop = wd[16:0];
            IDX_TRANSFORM_SATURATE_CONFIG: begin
               st_nxt.tone = wd[POS_TONE];
               st_nxt.numsel = wd[POS_NUMSEL];
               st_nxt.rev = wd[POS_REVERSE];
               st_nxt.rp = wd[POS_ROLLOFF +: 9];
               st_nxt.cp = wd[POS_PREFIX +: 11];
               st_nxt.subc = wd[0];
            end
            IDX_FREQ_WORD: st_nxt.fcw = wd[29:0];
            IDX_GAIN_LOAD: begin
               st_nxt.g8 = wd[POS_GAIN2 +: 8];
               st_nxt.g7 = wd[7:0];
               st_nxt.load = wd[POS_LOAD];
            end
            IDX_COEF_ADDR: st_nxt.caddr = wd[6:0];
            IDX_COEF_DATA: begin
               st_nxt.mem[st_r.caddr] = wd[29:0];
               st_nxt.caddr = st_r.caddr + 7'h01;
            end
            IDX_FIFO_CS: begin
               st_nxt.off1 = wd[POS_BUF1_OFF +: 4];
               st_nxt.off2 = wd[POS_BUF2_OFF +: 4];
               st_nxt.ie = wd[2:0];
               st_nxt.stop = 1'b0;
               st_nxt.ovf = 1'b0;
               st_nxt.unf = 1'b0;
            end
            IDX_SAT_STAT: st_nxt.saturation_status = 14'h0000;
            IDX_STG7_PWR: st_nxt.pwr7 = {wd[POS_INPHASE_POWER_THRESHOLD +: 12], wd[11:0]};
            IDX_STG8_PWR: st_nxt.pwr8 = {wd[POS_INPHASE_POWER_THRESHOLD +: 12], wd[11:0]};
            default: st_nxt.prbs_en = st_r.prbs_en;
         endcase
      end

      // Events win over a clearing write
      // latch stop
      if (proc_stop_evt_i) begin
         st_nxt.stop = 1'b1;
      end
      if (in_overflow_evt_i) begin
         st_nxt.ovf = 1'b1;
      end
      if (in_underflow_evt_i) begin
         st_nxt.unf = 1'b1;
      end
      st_nxt.saturation_status = st_nxt.saturation_status | (sat_evt_i & SAT_USED_MASK);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
         st_r.band <= RST_PRBS_BAND[25:0];
         st_r.tone <= RST_TRANSFORM_SATURATE_CONFIG[POS_TONE];
         st_r.numsel <= RST_TRANSFORM_SATURATE_CONFIG[POS_NUMSEL];
         st_r.rev <= RST_TRANSFORM_SATURATE_CONFIG[POS_REVERSE];
         st_r.rp <= RST_TRANSFORM_SATURATE_CONFIG[POS_ROLLOFF +: 9];
         st_r.cp <= RST_TRANSFORM_SATURATE_CONFIG[POS_PREFIX +: 11];
         st_r.subc <= RST_TRANSFORM_SATURATE_CONFIG[0];
         st_r.g8 <= RST_GAIN_LOAD[POS_GAIN2 +: 8];
         st_r.g7 <= RST_GAIN_LOAD[7:0];
         st_r.off1 <= RST_FIFO_CS[POS_BUF1_OFF +: 4];
         st_r.off2 <= RST_FIFO_CS[POS_BUF2_OFF +: 4];
         st_r.ie <= RST_FIFO_CS[2:0];
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign avs_readdata_o = st_r.rdata;
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_r.ack;
   assign coef_rd_data_o = st_r.crd;
   assign prbs_enable_o = st_r.prbs_en;
   assign prbs_upper_edge_o = st_r.band[POS_UPPER_EDGE +: 13];
   assign prbs_lower_edge_o = st_r.band[12:0];
   assign loop_count_o = st_r.loop[15:0];
   assign loop_count_en_o = st_r.loop[POS_LOOP_EN];
   assign loop_wrap_o = st_r.loop_wrap;
   assign tone_output_sel_o = st_r.tone;
   assign numeric_prog_sel_o = st_r.numsel;
   assign rolloff_reverse_o = st_r.rev;
   assign rolloff_period_o = st_r.rp_dec;
   assign cyclic_prefix_len_o = st_r.cp_dec;
   assign subcarrier_count_sel_o = st_r.subc;
   assign osc_freq_word_o = st_r.fcw;
   assign freq_word_load_o = st_r.load;
   assign first_gain_stage_o = st_r.g7;
   assign second_gain_stage_o = st_r.g8;
   assign buf_one_ptr_offset_o = st_r.off1;
   assign buf_two_ptr_offset_o = st_r.off2;
   assign stage7_inphase_power_threshold_o = st_r.pwr7[23:12];
   assign stage7_quadrature_power_threshold_o = st_r.pwr7[11:0];
   assign stage8_inphase_power_threshold_o = st_r.pwr8[23:12];
   assign stage8_quadrature_power_threshold_o = st_r.pwr8[11:0];
   assign chan_irq_o = (st_r.stop & st_r.ie[2]) | (st_r.ovf & st_r.ie[1])
                       | (st_r.unf & st_r.ie[0]);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [29:0] exp_coef; // Expected fetch word
   // Reverse order counts down from the top entry, 127 minus the index
   assign exp_coef = st_r.rev ? st_r.mem[7'h7F - coef_rd_idx_i] : st_r.mem[coef_rd_idx_i];

   a_load_pulse_once: assert property (
      (acc_wr && widx == IDX_GAIN_LOAD && avs_byteenable_i[2] && avs_writedata_i[16])
      |=> freq_word_load_o ##1 !freq_word_load_o)
      else $error("Load pulse not exactly one cycle");
   a_stop_sticky_set: assert property (
      // Flag stays up unless a clearing write was accepted in the cycle before
      proc_stop_evt_i |=> st_r.stop ##1
         (st_r.stop || $past(acc_wr && widx == IDX_FIFO_CS)))
      else $error("Stop flag not held after event");
   a_fifo_flag_clear: assert property (
      (acc_wr && widx == IDX_FIFO_CS && !in_overflow_evt_i && !in_underflow_evt_i)
      |=> !st_r.ovf && !st_r.unf)
      else $error("Fifo flags not cleared by write");
   a_irq_from_stop: assert property (
      (st_r.stop && st_r.ie[2]) |-> chan_irq_o)
      else $error("Interrupt missing for enabled stop");
   a_coef_addr_step: assert property (
      (acc_wr && widx == IDX_COEF_DATA) |=> st_r.caddr == 7'($past(st_r.caddr) + 7'h01))
      else $error("Coefficient address did not advance");
   a_coef_fetch_order: assert property (
      (avs_write_i == 1'b0) |=> coef_rd_data_o == $past(exp_coef))
      else $error("Coefficient fetch order wrong");
   a_prefix_enum_max: assert property (
      // Decoded outputs trail the fields by one edge, so skip the reset edge
      (rst_n_i && !st_r.numsel && st_r.cp[2:0] == 3'h4) |=> cyclic_prefix_len_o == PREFIX_MAX)
      else $error("Prefix enum four not 1024");
   a_rolloff_enum_one: assert property (
      (rst_n_i && !st_r.numsel && st_r.rp[2:0] == 3'h1) |=> rolloff_period_o == ROLLOFF_STEP)
      else $error("Rolloff enum one not 64");
   a_sat_latch: assert property (
      sat_evt_i[0] |=> st_r.saturation_status[0])
      else $error("Transform saturation not latched");
   a_bus_one_wait: assert property (
      (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
      else $error("Read not answered after one wait");

   c_load_pulse: cover property (freq_word_load_o);
   c_stop_irq: cover property (st_r.stop && chan_irq_o);
   c_reverse_fetch: cover property (st_r.rev && coef_rd_idx_i == 7'h00);
   c_loop_wrap: cover property (loop_wrap_o);
   // Numeric prefix beyond the limit is clamped
   c_prefix_clamp: cover property (st_r.numsel && st_r.cp > PREFIX_MAX);

endmodule // oifr_chan_regs

// ===== hw/oifr_pkg.sv
// Constants, register map and field layout of the OFDM TRANSFORM_SATURATE channel register bank.
// Assumes one core clock domain and a 32-bit Avalon-MM slave with byte addresses.
package oifr_pkg;

   // ---------------------------------------------------------------
   // Register word indices (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam logic [11:0] IDX_PRBS_BAND = 12'h74C;
   localparam logic [11:0] IDX_PRBS_LOOP = 12'h74D;
   localparam logic [11:0] IDX_TRANSFORM_SATURATE_CONFIG = 12'h7B0;
   localparam logic [11:0] IDX_FREQ_WORD = 12'h7B1;
   localparam logic [11:0] IDX_GAIN_LOAD = 12'h7B2;
   localparam logic [11:0] IDX_COEF_ADDR = 12'h7B3;
   localparam logic [11:0] IDX_COEF_DATA = 12'h7B4;
   localparam logic [11:0] IDX_FIFO_CS = 12'h7B5;
   localparam logic [11:0] IDX_SAT_STAT = 12'h7B6;
   localparam logic [11:0] IDX_STG7_PWR = 12'h7B7;
   localparam logic [11:0] IDX_STG8_PWR = 12'h7B8;
   localparam logic [11:0] IDX_PRBS_MODE = 12'h7C0;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int POS_UPPER_EDGE = 13;
   localparam int POS_LOOP_EN = 16;
   localparam int POS_TONE = 27;
   localparam int POS_NUMSEL = 26;
   localparam int POS_REVERSE = 25;
   localparam int POS_ROLLOFF = 16;
   localparam int POS_PREFIX = 1;
   localparam int POS_LOAD = 16;
   localparam int POS_GAIN2 = 8;
   localparam int POS_BUF1_OFF = 28;
   localparam int POS_BUF2_OFF = 24;
   localparam int POS_VALID = 6;
   localparam int POS_STOP = 5;
   localparam int POS_OVF = 4;
   localparam int POS_UNF = 3;
   localparam int POS_INPHASE_POWER_THRESHOLD = 16;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_PRBS_BAND = 32'h01EFE080;
   localparam logic [31:0] RST_TRANSFORM_SATURATE_CONFIG = 32'h00040008;
   localparam logic [31:0] RST_GAIN_LOAD = 32'h00008080;
   localparam logic [31:0] RST_FIFO_CS = 32'h11000007;
   localparam logic [31:0] RST_ZERO = 32'h00000000;

   // ---------------------------------------------------------------
   // Decode limits and enumerated settings
   // ---------------------------------------------------------------
   localparam logic [8:0] ROLLOFF_MAX = 9'h100;
   localparam logic [8:0] ROLLOFF_STEP = 9'h040;
   localparam logic [10:0] PREFIX_MAX = 11'h400;
   localparam logic [10:0] PREFIX_E0 = 11'h0C0;
   localparam logic [10:0] PREFIX_E1 = 11'h100;
   localparam logic [10:0] PREFIX_E2 = 11'h200;
   localparam logic [10:0] PREFIX_E3 = 11'h300;
   localparam logic [13:0] SAT_USED_MASK = 14'h3DEF;

endpackage : oifr_pkg

// ===== test/tb_top.sv
// Self-checking bench for the OFDM TRANSFORM_SATURATE channel register bank.
// Assumes the package constants and a one-wait-state Avalon-MM slave.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); fails++; end end
module tb_top;
   import oifr_pkg::*;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [13:0] avs_address_i = 14'h0000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic transform_saturate_out_valid_i = 1'b0;
   logic proc_stop_evt_i = 1'b0;
   logic in_overflow_evt_i = 1'b0;
   logic in_underflow_evt_i = 1'b0;
   logic [13:0] sat_evt_i = 14'h0000;
   logic [6:0] coef_rd_idx_i = 7'h00;
   logic [29:0] coef_rd_data_o;
   logic prbs_enable_o, loop_count_en_o, loop_wrap_o, tone_output_sel_o;
   logic numeric_prog_sel_o, rolloff_reverse_o, subcarrier_count_sel_o;
   logic freq_word_load_o, chan_irq_o;
   logic [12:0] prbs_upper_edge_o, prbs_lower_edge_o;
   logic [15:0] loop_count_o;
   logic [8:0] rolloff_period_o;
   logic [10:0] cyclic_prefix_len_o;
   logic [29:0] osc_freq_word_o;
   logic [7:0] first_gain_stage_o, second_gain_stage_o;
   logic [3:0] buf_one_ptr_offset_o, buf_two_ptr_offset_o;
   logic [11:0] s7_i_o, s7_q_o, s8_i_o, s8_q_o;
   int fails = 0;
   int cmp_count = 0;
   int load_pulses = 0;
   int wrap_pulses = 0;
   int wrap0;
   logic [31:0] rdv;
   logic [8:0] roll_tab [5] = '{9'h000, 9'h040, 9'h080, 9'h0C0, 9'h100};
   logic [10:0] pfx_tab [5] = '{PREFIX_E0, PREFIX_E1, PREFIX_E2, PREFIX_E3, PREFIX_MAX};

   oifr_chan_regs uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .transform_saturate_out_valid_i(transform_saturate_out_valid_i), .proc_stop_evt_i(proc_stop_evt_i),
      .in_overflow_evt_i(in_overflow_evt_i), .in_underflow_evt_i(in_underflow_evt_i),
      .sat_evt_i(sat_evt_i), .coef_rd_idx_i(coef_rd_idx_i), .coef_rd_data_o(coef_rd_data_o),
      .prbs_enable_o(prbs_enable_o), .prbs_upper_edge_o(prbs_upper_edge_o),
      .prbs_lower_edge_o(prbs_lower_edge_o), .loop_count_o(loop_count_o),
      .loop_count_en_o(loop_count_en_o), .loop_wrap_o(loop_wrap_o),
      .tone_output_sel_o(tone_output_sel_o), .numeric_prog_sel_o(numeric_prog_sel_o),
      .rolloff_reverse_o(rolloff_reverse_o), .rolloff_period_o(rolloff_period_o),
      .cyclic_prefix_len_o(cyclic_prefix_len_o),
      .subcarrier_count_sel_o(subcarrier_count_sel_o), .osc_freq_word_o(osc_freq_word_o),
      .freq_word_load_o(freq_word_load_o), .first_gain_stage_o(first_gain_stage_o),
      .second_gain_stage_o(second_gain_stage_o), .buf_one_ptr_offset_o(buf_one_ptr_offset_o),
      .buf_two_ptr_offset_o(buf_two_ptr_offset_o),
      .stage7_inphase_power_threshold_o(s7_i_o), .stage7_quadrature_power_threshold_o(s7_q_o),
      .stage8_inphase_power_threshold_o(s8_i_o), .stage8_quadrature_power_threshold_o(s8_q_o),
      .chan_irq_o(chan_irq_o));

   // -------------------------------------------------------------
   // Clock and load and wrap pulse counters
   // -------------------------------------------------------------
   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      if (freq_word_load_o === 1'b1) load_pulses++;
      if (loop_wrap_o === 1'b1) wrap_pulses++;
   end

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // One Avalon transfer; held until waitrequest is seen low at an edge
   task automatic bus(input logic [11:0] idx, input logic we, input logic [31:0] wd);
      int n;
      logic w;
      n = 0;
      avs_address_i <= {idx, 2'b00};
      avs_read_i <= ~we;
      avs_write_i <= we;
      avs_writedata_i <= wd;
      // Sample waitrequest and read data at the rising edge only
      do begin
         @(posedge core_clk_i);
         n++;
         w = avs_waitrequest_o;
         rdv = avs_readdata_o;
      end while (w !== 1'b0 && n < 20);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge core_clk_i);
      if (w !== 1'b0) begin
         fails++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
      bus(idx, 1'b1, wd);
   endtask

   task automatic rdchk(input string nm, input logic [11:0] idx, input logic [31:0] ex);
      bus(idx, 1'b0, 32'h00000000);
      `CHK(nm, ex, rdv)
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      // Reset values
      rdchk("band_rst", IDX_PRBS_BAND, RST_PRBS_BAND);
      rdchk("cfg_rst", IDX_TRANSFORM_SATURATE_CONFIG, RST_TRANSFORM_SATURATE_CONFIG);
      rdchk("gain_rst", IDX_GAIN_LOAD, RST_GAIN_LOAD);
      rdchk("fifo_rst", IDX_FIFO_CS, RST_FIFO_CS);
      rdchk("sat_rst", IDX_SAT_STAT, RST_ZERO);
      rdchk("unmapped", 12'h123, RST_ZERO);
      $display("test reset done");
      // Band edges, loop count and test mode
      wr(IDX_PRBS_BAND, 32'hFFFFE001);
      `CHK("upper", 13'h1FFF, prbs_upper_edge_o)
      `CHK("lower", 13'h0001, prbs_lower_edge_o)
      rdchk("band_rsvd", IDX_PRBS_BAND, 32'h03FFE001);
      // 4096 carriers plus 1024 prefix, minus one, with the enable bit
      wr(IDX_PRBS_LOOP, 32'h0001_13FF);
      wr(IDX_PRBS_MODE, 32'h00000001);
      `CHK("loop_cnt", 16'h13FF, loop_count_o)
      `CHK("loop_en", 1'b1, loop_count_en_o)
      `CHK("prbs_en", 1'b1, prbs_enable_o)
      // Short loop of four: counter restarts while test mode is off
      wr(IDX_PRBS_MODE, 32'h00000000);
      wr(IDX_PRBS_LOOP, 32'h0001_0003);
      wr(IDX_PRBS_MODE, 32'h00000001);
      wrap0 = wrap_pulses;
      repeat (17) @(posedge core_clk_i);
      `CHK("loop_wrap", 4, wrap_pulses - wrap0)
      $display("test prbs done");
      // Enumerated codes 0..4 for both fields
      for (int k = 0; k < 5; k++) begin
         wr(IDX_TRANSFORM_SATURATE_CONFIG, (32'(k) << POS_ROLLOFF) | (32'(k) << POS_PREFIX));
         repeat (2) @(posedge core_clk_i);
         `CHK("roll_enum", roll_tab[k], rolloff_period_o)
         `CHK("pfx_enum", pfx_tab[k], cyclic_prefix_len_o)
      end
      // Numeric values above the limits clamp
      wr(IDX_TRANSFORM_SATURATE_CONFIG, 32'h0F7D_0A59);
      repeat (2) @(posedge core_clk_i);
      `CHK("roll_clamp", ROLLOFF_MAX, rolloff_period_o)
      `CHK("pfx_clamp", PREFIX_MAX, cyclic_prefix_len_o)
      wr(IDX_TRANSFORM_SATURATE_CONFIG, 32'h0E7D_0459);
      repeat (2) @(posedge core_clk_i);
      `CHK("roll_num", 9'h07D, rolloff_period_o)
      `CHK("pfx_num", 11'h22C, cyclic_prefix_len_o)
      `CHK("tone", 1'b1, tone_output_sel_o)
      `CHK("numsel", 1'b1, numeric_prog_sel_o)
      `CHK("reverse", 1'b1, rolloff_reverse_o)
      `CHK("subcar", 1'b1, subcarrier_count_sel_o)
      $display("test config done");
      // Frequency word and load pulse
      wr(IDX_FREQ_WORD, 32'hFFFF_FFFF);
      `CHK("fcw", 30'h3FFFFFFF, osc_freq_word_o)
      wr(IDX_GAIN_LOAD, 32'h0001_35CA);
      repeat (3) @(posedge core_clk_i);
      `CHK("load_pulses", 1, load_pulses)
      `CHK("gain1", 8'hCA, first_gain_stage_o)
      `CHK("gain2", 8'h35, second_gain_stage_o)
      rdchk("load_clear", IDX_GAIN_LOAD, 32'h000035CA);
      $display("test gain done");
      // Coefficients at the top of the array, fetched reversed then forward
      wr(IDX_COEF_ADDR, 32'h0000007E);
      wr(IDX_COEF_DATA, 32'hC000_1111);
      wr(IDX_COEF_DATA, 32'h3FFF_2222);
      rdchk("coef_addr", IDX_COEF_ADDR, 32'h00000000);
      coef_rd_idx_i <= 7'h01;
      repeat (2) @(posedge core_clk_i);
      `CHK("coef_rev", 30'h00001111, coef_rd_data_o)
      wr(IDX_TRANSFORM_SATURATE_CONFIG, 32'h0000_0000);
      coef_rd_idx_i <= 7'h7F;
      repeat (2) @(posedge core_clk_i);
      `CHK("coef_fwd", 30'h3FFF2222, coef_rd_data_o)
      $display("test coef done");
      // Sticky flags, live valid and interrupt
      wr(IDX_FIFO_CS, 32'hA500_0004);
      transform_saturate_out_valid_i <= 1'b1;
      proc_stop_evt_i <= 1'b1;
      in_overflow_evt_i <= 1'b1;
      in_underflow_evt_i <= 1'b1;
      sat_evt_i <= 14'h3FFF;
      @(posedge core_clk_i);
      proc_stop_evt_i <= 1'b0;
      in_overflow_evt_i <= 1'b0;
      in_underflow_evt_i <= 1'b0;
      sat_evt_i <= 14'h0000;
      @(negedge core_clk_i);
      `CHK("irq_set", 1'b1, chan_irq_o)
      @(posedge core_clk_i);
      rdchk("fifo_flags", IDX_FIFO_CS, 32'hA500_007C);
      `CHK("offs", 8'hA5, {buf_one_ptr_offset_o, buf_two_ptr_offset_o})
      rdchk("sat_flags", IDX_SAT_STAT, {18'h0, SAT_USED_MASK});
      wr(IDX_FIFO_CS, 32'hA500_0003);
      @(negedge core_clk_i);
      `CHK("irq_clear", 1'b0, chan_irq_o)
      @(posedge core_clk_i);
      in_overflow_evt_i <= 1'b1;
      @(posedge core_clk_i);
      in_overflow_evt_i <= 1'b0;
      @(negedge core_clk_i);
      `CHK("irq_ovf", 1'b1, chan_irq_o)
      @(posedge core_clk_i);
      transform_saturate_out_valid_i <= 1'b0;
      wr(IDX_FIFO_CS, 32'hA500_0001);
      rdchk("fifo_clr", IDX_FIFO_CS, 32'hA500_0001);
      `CHK("irq_off", 1'b0, chan_irq_o)
      wr(IDX_SAT_STAT, 32'h0000_0000);
      rdchk("sat_clr", IDX_SAT_STAT, RST_ZERO);
      $display("test status done");
      // Power monitor thresholds
      wr(IDX_STG7_PWR, 32'hFABC_F123);
      wr(IDX_STG8_PWR, 32'h0456_0789);
      `CHK("s7i", 12'hABC, s7_i_o)
      `CHK("s7q", 12'h123, s7_q_o)
      `CHK("s8i", 12'h456, s8_i_o)
      `CHK("s8q", 12'h789, s8_q_o)
      rdchk("s7_rd", IDX_STG7_PWR, 32'h0ABC_0123);
      $display("test power done");
      tally_and_finish();
   end
endmodule // tb_top
